/* File: lpc_pkg.sv */
package lpc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int NEAR_CONV_NS = 540000;
   localparam int LED_PULSE_NS = 100000;
   localparam int LIGHT_CONV_NS = 100000000;
   localparam int SLEEP_STEP_NS = 12500000;
   localparam int NEAR_CONV_CYC = (NEAR_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LED_PULSE_CYC = (LED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LIGHT_CONV_CYC = (LIGHT_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEEP_STEP_CYC = (SLEEP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Sleep time in 12.5 ms steps, indexed by the sleep select code.
   localparam logic [6:0] SLEEP_STEPS [0:7] = '{7'h40, 7'h20, 7'h10, 7'h08,
                                               7'h06, 7'h04, 7'h01, 7'h00};
   // Consecutive trips needed, indexed by the persistence code.
   localparam logic [4:0] PERSIST_NEED [0:3] = '{5'h01, 5'h04, 5'h08, 5'h10};

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SETUP = 8'h01;
   localparam logic [7:0] ADDR_EVENT = 8'h02;
   localparam logic [7:0] ADDR_NEAR_LOW = 8'h03;
   localparam logic [7:0] ADDR_NEAR_HIGH = 8'h04;
   localparam logic [7:0] ADDR_LIGHT_LOW_LSB = 8'h05;
   localparam logic [7:0] ADDR_LIGHT_MID = 8'h06;
   localparam logic [7:0] ADDR_LIGHT_HIGH_MSB = 8'h07;
   localparam logic [7:0] ADDR_NEAR_DATA = 8'h08;
   localparam logic [7:0] ADDR_LIGHT_DATA_LSB = 8'h09;
   localparam logic [7:0] ADDR_LIGHT_DATA_MSB = 8'h0A;

   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [7:0] RST_EVENT = 8'h00;
   localparam logic [7:0] RST_NEAR_LOW = 8'h00;
   localparam logic [7:0] RST_NEAR_HIGH = 8'hFF;
   localparam logic [7:0] RST_LIGHT_LOW_LSB = 8'h00;
   localparam logic [7:0] RST_LIGHT_MID = 8'hF0;
   localparam logic [7:0] RST_LIGHT_HIGH_MSB = 8'hFF;
   localparam logic [7:0] RD_NONE = 8'h00;

   // Setup register fields.
   localparam int NEAR_EN_BIT = 7;
   localparam int SLEEP_MSB = 6;
   localparam int SLEEP_LSB = 4;
   localparam int DRIVE_BIT = 3;
   localparam int LIGHT_EN_BIT = 2;
   localparam int RANGE_BIT = 1;
   localparam int SPECTRUM_BIT = 0;

   // Event control register fields.
   localparam int NEAR_FLAG_BIT = 7;
   localparam int NEAR_PRST_LSB = 5;
   localparam int LIGHT_FLAG_BIT = 3;
   localparam int LIGHT_PRST_LSB = 1;
   localparam int COMBINE_BIT = 0;

   // Bus slave address: upper six bits fixed, lowest from the select pin.
   localparam logic [5:0] DEV_ADDR_HI = 6'h22;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [1:0] {
      NEAR_IDLE = 2'b00,
      NEAR_CONV = 2'b01,
      NEAR_SLEEP = 2'b10
   } lpc_near_state_e;

   typedef enum logic [2:0] {
      I2C_IDLE = 3'b000,
      I2C_ADDR = 3'b001,
      I2C_ACK = 3'b010,
      I2C_WRITE = 3'b011,
      I2C_READ = 3'b100,
      I2C_MACK = 3'b101
   } lpc_i2c_state_e;

endpackage : lpc_pkg

/* File: lpc_i2c_slave.sv */
module lpc_i2c_slave
   import lpc_pkg::*;
(
   input wire logic mclk, // System clock.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic clk_en, // Freezes all state while low.
   input wire logic scl, // Synchronised bus clock.
   input wire logic sda, // Synchronised bus data.
   input wire logic [6:0] dev_addr, // Own slave address.
   input wire logic [7:0] rd_data, // Register value at reg_addr.
   output logic [7:0] reg_addr, // Register pointer.
   output logic wr_stb, // One-cycle write strobe.
   output logic [7:0] wr_data, // Write data with wr_stb.
   output logic sda_oe // Pulls the data line low while high.
);

   lpc_i2c_state_e state_ff;
   logic scl_d_ff, sda_d_ff, rw_ff, first_ff, inc_ff, nack_ff, wr_stb_ff, sda_oe_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] sh_ff, ptr_ff, wr_data_ff;
   logic start_cond, stop_cond, scl_rise, scl_fall;

   assign start_cond = scl && scl_d_ff && sda_d_ff && !sda;
   assign stop_cond = scl && scl_d_ff && !sda_d_ff && sda;
   assign scl_rise = scl && !scl_d_ff;
   assign scl_fall = !scl && scl_d_ff;
   assign reg_addr = ptr_ff;
   assign wr_stb = wr_stb_ff;
   assign wr_data = wr_data_ff;
   assign sda_oe = sda_oe_ff;

   // ---------------------------------------------------------------
   // Byte engine
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_ff <= I2C_IDLE;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         rw_ff <= 1'b0;
         first_ff <= 1'b0;
         inc_ff <= 1'b0;
         nack_ff <= 1'b0;
         wr_stb_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         bit_cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 8'h00;
         wr_data_ff <= 8'h00;
      end else if (clk_en) begin
         scl_d_ff <= scl;
         sda_d_ff <= sda;
         wr_stb_ff <= 1'b0;
         if (start_cond) begin
            state_ff <= I2C_ADDR;
            bit_cnt_ff <= 4'h0;
            first_ff <= 1'b1;
            inc_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
         end else if (stop_cond) begin
            state_ff <= I2C_IDLE;
            sda_oe_ff <= 1'b0;
         end else begin
            case (state_ff)
               I2C_ADDR, I2C_WRITE: begin
                  if (scl_rise) begin
                     sh_ff <= {sh_ff[6:0], sda};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && bit_cnt_ff == BYTE_BITS) begin
                     if (state_ff == I2C_ADDR) begin
                        if (sh_ff[7:1] == dev_addr) begin
                           rw_ff <= sh_ff[0];
                           sda_oe_ff <= 1'b1;
                           state_ff <= I2C_ACK;
                        end else begin
                           state_ff <= I2C_IDLE;
                        end
                     end else begin
                        sda_oe_ff <= 1'b1;
                        state_ff <= I2C_ACK;
                        if (first_ff) begin
                           ptr_ff <= sh_ff;
                           first_ff <= 1'b0;
                        end else begin
                           wr_stb_ff <= 1'b1;
                           wr_data_ff <= sh_ff;
                           inc_ff <= 1'b1;
                        end
                     end
                  end
               end
               I2C_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= 4'h0;
                     if (inc_ff) begin
                        ptr_ff <= ptr_ff + 8'h01;
                        inc_ff <= 1'b0;
                     end
                     if (rw_ff) begin
                        sh_ff <= rd_data;
                        sda_oe_ff <= !rd_data[7];
                        state_ff <= I2C_READ;
                     end else begin
                        sda_oe_ff <= 1'b0;
                        state_ff <= I2C_WRITE;
                     end
                  end
               end
               I2C_READ: begin
                  if (scl_rise) begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt_ff == BYTE_BITS) begin
                        sda_oe_ff <= 1'b0;
                        ptr_ff <= ptr_ff + 8'h01;
                        state_ff <= I2C_MACK;
                     end else begin
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        sda_oe_ff <= !sh_ff[6];
                     end
                  end
               end
               I2C_MACK: begin
                  if (scl_rise) begin
                     nack_ff <= sda;
                  end else if (scl_fall) begin
                     if (nack_ff) begin
                        state_ff <= I2C_IDLE;
                     end else begin
                        sh_ff <= rd_data;
                        sda_oe_ff <= !rd_data[7];
                        bit_cnt_ff <= 4'h0;
                        state_ff <= I2C_READ;
                     end
                  end
               end
               default: begin
                  state_ff <= I2C_IDLE;
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : lpc_i2c_slave

/* File: lpc_sensor_top.sv */
// How it works
// - Near enable runs conversions, result after 0.54ms.
// - Sleep field selects idle time between pulses.
// - Drive bit picks 110mA or 220mA sink.
// - Light enable runs conversions every 100ms.
// - Range bit picks low or high lux.
// - Spectrum bit picks visible or infrared data.
// - Near flag sticky, cleared by writing zero.
// - Near persistence needs 1/4/8/16 trips.
// - Light flag sticky, cleared by writing zero.
// - Light persistence needs 1/4/8/16 trips.
// - Combine bit picks OR or AND interrupt.
// - Near low limit register, resets 0x00.
// - Near high limit register, resets 0xFF.
// - Light low limit low byte at 0x05.
// - Setup and control fields reset to zero.
// - Offset 0x06 splits light limit nibbles.
// - Near result readable at 0x08.
// - Registers reached through bus slave address.
module lpc_sensor_top
   import lpc_pkg::*;
#(
   parameter int NEAR_CONV_CYCLES = NEAR_CONV_CYC,
   parameter int LED_PULSE_CYCLES = LED_PULSE_CYC,
   parameter int LIGHT_CONV_CYCLES = LIGHT_CONV_CYC,
   parameter int SLEEP_STEP_CYCLES = SLEEP_STEP_CYC
) (
   input wire logic mclk, // System clock, 100 MHz.
   input wire logic reset, // Asynchronous reset, active high.
   input wire logic clk_en, // Freezes all state while low.
   input wire logic scl_pin, // Bus clock pin.
   input wire logic sda_in, // Bus data pin level.
   output logic sda_out, // Bus data drive value, always low.
   output logic sda_oe, // Bus data pulled low while high.
   input wire logic addr_select_pin, // Lowest slave address bit.
   output logic int_n, // Interrupt, active low.
   output logic led_sink_output, // LED current sink pulse.
   output logic led_drive_select, // Sink strength, high for the larger.
   output logic near_conv_active, // Near converter running.
   output logic light_conv_active, // Light converter running.
   output logic light_range_select, // High-lux range while high.
   output logic spectrum_select, // Infrared spectrum while high.
   input wire logic [7:0] near_result, // Near converter output.
   input wire logic [11:0] light_result // Light converter output.
);

   if (LED_PULSE_CYCLES < 1 || NEAR_CONV_CYCLES <= LED_PULSE_CYCLES ||
       LIGHT_CONV_CYCLES < 1 || SLEEP_STEP_CYCLES < 1 ||
       SLEEP_STEP_CYCLES > (32'hFFFF_FFFF >> 6)) begin : g_bad_params
      $error("Conversion timing parameters out of range.");
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff, addr_meta_ff, addr_sync_ff;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         scl_meta_ff <= 1'b1;
         scl_sync_ff <= 1'b1;
         sda_meta_ff <= 1'b1;
         sda_sync_ff <= 1'b1;
         addr_meta_ff <= 1'b0;
         addr_sync_ff <= 1'b0;
      end else if (clk_en) begin
         scl_meta_ff <= scl_pin;
         scl_sync_ff <= scl_meta_ff;
         sda_meta_ff <= sda_in;
         sda_sync_ff <= sda_meta_ff;
         addr_meta_ff <= addr_select_pin;
         addr_sync_ff <= addr_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   logic [7:0] reg_addr, wr_data, rd_data;
   logic wr_stb;

   lpc_i2c_slave u_slave (
      .mclk(mclk),
      .reset(reset),
      .clk_en(clk_en),
      .scl(scl_sync_ff),
      .sda(sda_sync_ff),
      .dev_addr({DEV_ADDR_HI, addr_sync_ff}),
      .rd_data(rd_data),
      .reg_addr(reg_addr),
      .wr_stb(wr_stb),
      .wr_data(wr_data),
      .sda_oe(sda_oe)
   );

   // ---------------------------------------------------------------
   // Configuration and threshold registers
   // ---------------------------------------------------------------
   logic [7:0] setup_ff, near_low_ff, near_high_ff, light_low_lsb_ff, light_mid_ff;
   logic [7:0] light_high_msb_ff, near_data_ff, event_ctl_ff;
   logic [11:0] light_data_ff, light_low_limit, light_high_limit;
   logic [1:0] flag_set;

   assign light_low_limit = {light_mid_ff[3:0], light_low_lsb_ff};
   assign light_high_limit = {light_high_msb_ff, light_mid_ff[7:4]};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         setup_ff <= RST_SETUP;
         near_low_ff <= RST_NEAR_LOW;
         near_high_ff <= RST_NEAR_HIGH;
         light_low_lsb_ff <= RST_LIGHT_LOW_LSB;
         light_mid_ff <= RST_LIGHT_MID;
         light_high_msb_ff <= RST_LIGHT_HIGH_MSB;
      end else if (clk_en && wr_stb) begin
         case (reg_addr)
            ADDR_SETUP: setup_ff <= wr_data;
            ADDR_NEAR_LOW: near_low_ff <= wr_data;
            ADDR_NEAR_HIGH: near_high_ff <= wr_data;
            ADDR_LIGHT_LOW_LSB: light_low_lsb_ff <= wr_data;
            ADDR_LIGHT_MID: light_mid_ff <= wr_data;
            ADDR_LIGHT_HIGH_MSB: light_high_msb_ff <= wr_data;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Event control register
   // ---------------------------------------------------------------
   // A flag that is set in the cycle of a clearing write stays set.
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         event_ctl_ff <= RST_EVENT;
      end else if (clk_en) begin
         if (wr_stb && reg_addr == ADDR_EVENT) begin
            event_ctl_ff <= wr_data;
            event_ctl_ff[NEAR_FLAG_BIT] <= flag_set[0] ||
               (event_ctl_ff[NEAR_FLAG_BIT] && wr_data[NEAR_FLAG_BIT]);
            event_ctl_ff[LIGHT_FLAG_BIT] <= flag_set[1] ||
               (event_ctl_ff[LIGHT_FLAG_BIT] && wr_data[LIGHT_FLAG_BIT]);
         end else begin
            if (flag_set[0]) begin
               event_ctl_ff[NEAR_FLAG_BIT] <= 1'b1;
            end
            if (flag_set[1]) begin
               event_ctl_ff[LIGHT_FLAG_BIT] <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      case (reg_addr)
         ADDR_SETUP: rd_data = setup_ff;
         ADDR_EVENT: rd_data = event_ctl_ff;
         ADDR_NEAR_LOW: rd_data = near_low_ff;
         ADDR_NEAR_HIGH: rd_data = near_high_ff;
         ADDR_LIGHT_LOW_LSB: rd_data = light_low_lsb_ff;
         ADDR_LIGHT_MID: rd_data = light_mid_ff;
         ADDR_LIGHT_HIGH_MSB: rd_data = light_high_msb_ff;
         ADDR_NEAR_DATA: rd_data = near_data_ff;
         ADDR_LIGHT_DATA_LSB: rd_data = light_data_ff[7:0];
         ADDR_LIGHT_DATA_MSB: rd_data = {4'h0, light_data_ff[11:8]};
         default: rd_data = RD_NONE;
      endcase
   end

   // ---------------------------------------------------------------
   // Near conversion sequencer
   // ---------------------------------------------------------------
   lpc_near_state_e near_state_ff;
   logic [31:0] near_cnt_ff, sleep_cycles;
   logic near_en, near_done, light_done;
   logic [31:0] light_cnt_ff;

   assign near_en = setup_ff[NEAR_EN_BIT];
   assign sleep_cycles = 32'(SLEEP_STEPS[setup_ff[SLEEP_MSB:SLEEP_LSB]] * SLEEP_STEP_CYCLES);
   assign near_done = near_state_ff == NEAR_CONV && near_cnt_ff == 32'(NEAR_CONV_CYCLES - 1);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         near_state_ff <= NEAR_IDLE;
         near_cnt_ff <= 32'h0;
      end else if (clk_en) begin
         if (!near_en) begin
            near_state_ff <= NEAR_IDLE;
            near_cnt_ff <= 32'h0;
         end else begin
            case (near_state_ff)
               NEAR_IDLE: begin
                  near_state_ff <= NEAR_CONV;
                  near_cnt_ff <= 32'h0;
               end
               NEAR_CONV: begin
                  near_cnt_ff <= near_done ? 32'h0 : near_cnt_ff + 32'h1;
                  if (near_done && sleep_cycles != 32'h0) begin
                     near_state_ff <= NEAR_SLEEP;
                  end
               end
               NEAR_SLEEP: begin
                  if (near_cnt_ff >= sleep_cycles - 32'h1) begin
                     near_state_ff <= NEAR_CONV;
                     near_cnt_ff <= 32'h0;
                  end else begin
                     near_cnt_ff <= near_cnt_ff + 32'h1;
                  end
               end
               default: begin
                  near_state_ff <= NEAR_IDLE;
                  near_cnt_ff <= 32'h0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Light conversion timer
   // ---------------------------------------------------------------
   assign light_done = setup_ff[LIGHT_EN_BIT] && light_cnt_ff == 32'(LIGHT_CONV_CYCLES - 1);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         light_cnt_ff <= 32'h0;
      end else if (clk_en) begin
         if (!setup_ff[LIGHT_EN_BIT] || light_done) begin
            light_cnt_ff <= 32'h0;
         end else begin
            light_cnt_ff <= light_cnt_ff + 32'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Results and persistence
   // ---------------------------------------------------------------
   logic [1:0] conv_done, conv_trip;
   logic [1:0] prst_code [0:1];

   assign conv_done = {light_done, near_done};
   assign conv_trip[0] = near_result > near_high_ff;
   assign conv_trip[1] = light_result < light_low_limit || light_result > light_high_limit;
   assign prst_code[0] = event_ctl_ff[NEAR_PRST_LSB +: 2];
   assign prst_code[1] = event_ctl_ff[LIGHT_PRST_LSB +: 2];

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         near_data_ff <= 8'h00;
         light_data_ff <= 12'h000;
      end else if (clk_en) begin
         if (near_done) begin
            near_data_ff <= near_result;
         end
         if (light_done) begin
            light_data_ff <= light_result;
         end
      end
   end

   for (genvar ch = 0; ch < 2; ch++) begin : g_persist
      logic [4:0] trip_cnt_ff;
      logic [4:0] trip_next;

      assign trip_next = trip_cnt_ff + 5'h01;
      assign flag_set[ch] = conv_done[ch] && conv_trip[ch] &&
                            trip_next >= PERSIST_NEED[prst_code[ch]];

      always_ff @(posedge mclk or posedge reset) begin
         if (reset) begin
            trip_cnt_ff <= 5'h00;
         end else if (clk_en && conv_done[ch]) begin
            if (!conv_trip[ch]) begin
               trip_cnt_ff <= 5'h00;
            end else if (trip_cnt_ff != PERSIST_NEED[3]) begin
               trip_cnt_ff <= trip_next;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Output registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         int_n <= 1'b1;
         sda_out <= 1'b0;
         led_sink_output <= 1'b0;
         led_drive_select <= 1'b0;
         near_conv_active <= 1'b0;
         light_conv_active <= 1'b0;
         light_range_select <= 1'b0;
         spectrum_select <= 1'b0;
      end else if (clk_en) begin
         int_n <= !(event_ctl_ff[COMBINE_BIT] ?
                    (event_ctl_ff[NEAR_FLAG_BIT] && event_ctl_ff[LIGHT_FLAG_BIT]) :
                    (event_ctl_ff[NEAR_FLAG_BIT] || event_ctl_ff[LIGHT_FLAG_BIT]));
         led_sink_output <= near_en && near_state_ff == NEAR_CONV &&
                            near_cnt_ff < 32'(LED_PULSE_CYCLES);
         led_drive_select <= setup_ff[DRIVE_BIT];
         near_conv_active <= near_en && near_state_ff == NEAR_CONV;
         light_conv_active <= setup_ff[LIGHT_EN_BIT];
         light_range_select <= setup_ff[RANGE_BIT];
         spectrum_select <= setup_ff[SPECTRUM_BIT];
         sda_out <= 1'b0;
      end
   end

endmodule : lpc_sensor_top

/* File: lpc_sensor_top_assertions.sv */
module lpc_sensor_top_assertions #(
   parameter int NEAR_CONV_CYCLES = 60,
   parameter int LED_PULSE_CYCLES = 10
) (
   input wire logic mclk, // System clock.
   input wire logic reset, // Asynchronous reset.
   input wire logic clk_en, // Clock enable.
   input wire logic scl_pin, // Bus clock pin.
   input wire logic sda_out, // Data drive value.
   input wire logic sda_oe, // Data pull-down enable.
   input wire logic led_sink_output, // LED pulse.
   input wire logic near_conv_active // Near conversion window.
);
   logic [15:0] conv_ff;
   logic [15:0] led_ff;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         conv_ff <= 16'h0000;
         led_ff <= 16'h0000;
      end else if (clk_en) begin
         conv_ff <= !near_conv_active ? 16'h0000 :
            (led_sink_output && led_ff == 16'h0000) ? 16'h0001 : conv_ff + 16'h0001;
         led_ff <= led_sink_output ? led_ff + 16'h0001 : 16'h0000;
      end
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (reset);
   a_sda_drive_low: assert property (sda_out == 1'b0) else $error("drive not low");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_pin) else $error("oe moved");
   a_led_in_conv: assert property (led_sink_output |-> near_conv_active)
      else $error("LED outside conversion");
   a_led_min_width: assert property ($rose(led_sink_output) |->
      (led_sink_output || !near_conv_active) [*8])
      else $error("LED pulse short");
   a_led_max_width: assert property (led_ff <= 16'(LED_PULSE_CYCLES))
      else $error("LED pulse long");
   a_conv_max_len: assert property (conv_ff <= 16'(NEAR_CONV_CYCLES))
      else $error("conversion long");
   a_led_at_start: assert property ($rose(led_sink_output) |->
      conv_ff <= 16'h0001 || conv_ff == 16'(NEAR_CONV_CYCLES))
      else $error("LED not at start");
   a_conv_has_led: assert property ($rose(near_conv_active) |-> ##[0:1] led_sink_output)
      else $error("conversion without LED");
endmodule : lpc_sensor_top_assertions

bind lpc_sensor_top lpc_sensor_top_assertions #(.NEAR_CONV_CYCLES(NEAR_CONV_CYCLES),
   .LED_PULSE_CYCLES(LED_PULSE_CYCLES)) u_chk (.mclk(mclk), .reset(reset), .clk_en(clk_en),
   .scl_pin(scl_pin),
   .sda_out(sda_out), .sda_oe(sda_oe), .led_sink_output(led_sink_output),
   .near_conv_active(near_conv_active));

/* File: lpc_i2c_host.sv */
module lpc_i2c_host (
   input wire logic mclk, // System clock.
   input wire logic sda_oe, // Device pulls data low.
   output logic scl_pin, // Bus clock.
   output logic sda_line // Data line level.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic low_ff = 1'b0;
   initial scl_pin = 1'b1;
   // The pull-up wins unless either party holds the line low.
   assign sda_line = !(low_ff | sda_oe);
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_n
   // A start when a is low, a stop when a is high.
   task automatic frame(input logic a);
      scl_pin <= 1'b0;
      wait_n(3);
      low_ff <= a;
      wait_n(3);
      scl_pin <= 1'b1;
      wait_n(6);
      low_ff <= !a;
      wait_n(6);
   endtask : frame
   task automatic bit_io(input logic b, output logic r);
      scl_pin <= 1'b0;
      wait_n(3);
      low_ff <= !b;
      wait_n(3);
      scl_pin <= 1'b1;
      wait_n(6);
      r = sda_line;
   endtask : bit_io
   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
      output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(last, ack);
   endtask : byte_io
endmodule : lpc_i2c_host

/* File: lpc_sensor_top_tb.sv */
module lpc_sensor_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic sel = 1'b1;
   logic en = 1'b1;
   logic [7:0] near_res = 8'h00;
   logic [11:0] light_res = 12'h000;
   logic scl_pin, sda_line, sda_oe, int_n, near_on, sda_drv, led;
   logic [3:0] outs;
   logic [7:0] rst_v [5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
   int n_errors = 0;
   int checked = 0;
   initial begin
      forever #5 mclk = ~mclk;
   end
   lpc_sensor_top #(.NEAR_CONV_CYCLES(60), .LED_PULSE_CYCLES(10), .LIGHT_CONV_CYCLES(200),
      .SLEEP_STEP_CYCLES(20)) u_dut (.mclk(mclk), .reset(reset), .clk_en(en),
      .scl_pin(scl_pin), .sda_in(sda_line), .sda_out(sda_drv), .sda_oe(sda_oe),
      .addr_select_pin(sel), .int_n(int_n), .led_sink_output(led), .led_drive_select(outs[3]),
      .near_conv_active(near_on), .light_conv_active(outs[2]), .light_range_select(outs[1]),
      .spectrum_select(outs[0]), .near_result(near_res), .light_result(light_res));
   lpc_i2c_host u_host (.mclk(mclk), .sda_oe(sda_oe), .scl_pin(scl_pin), .sda_line(sda_line));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic r,
      output logic [7:0] q);
      logic k;
      u_host.frame(1'b0);
      u_host.byte_io({6'h22, sel, 1'b0}, 1'b1, q, k);
      u_host.byte_io(a, 1'b1, q, k);
      if (r) begin
         u_host.frame(1'b0);
         u_host.byte_io({6'h22, sel, 1'b1}, 1'b1, q, k);
         u_host.byte_io(8'hFF, 1'b1, q, k);
      end else begin
         u_host.byte_io(d, 1'b1, q, k);
      end
      u_host.frame(1'b1);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(a, d, 1'b0, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      xfer(a, 8'h00, 1'b1, q);
      cmp(q, e);
   endtask : rd
   task automatic end_of_test();
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   initial begin
      logic [7:0] q;
      logic k;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 5; i++) rd(8'(i + 1), rst_v[i]);
      cmp({6'h00, sda_drv, int_n}, 8'h01);
      rd(8'h0B, 8'h00);
      for (int s = 0; s < 2; s++) begin
         sel <= s[0];
         u_host.frame(1'b0);
         u_host.byte_io({6'h22, 1'b0, 1'b0}, 1'b1, q, k);
         u_host.frame(1'b1);
         cmp({7'h00, k}, 8'(s));
      end
      for (int i = 3; i < 6; i++) begin
         wr(8'(i), 8'(8'hA5 + i));
         rd(8'(i), 8'(8'hA5 + i));
      end
      for (int b = 0; b < 4; b++) begin
         wr(8'h01, 8'(1 << b));
         cmp({4'h0, outs}, 8'(1 << b));
      end
      wr(8'h04, 8'h10);
      near_res <= 8'h20;
      wr(8'h02, 8'h20);
      wr(8'h01, 8'hE0);
      for (int n = 1; n <= 4; n++) begin
         @(negedge near_on);
         repeat (3) @(posedge mclk);
         cmp({7'h00, int_n}, 8'(n < 4));
      end
      @(posedge near_on);
      @(posedge mclk);
      cmp({7'h00, led}, 8'h01);
      rd(8'h08, 8'h20);
      near_res <= 8'h00;
      wr(8'h01, 8'h00);
      wr(8'h02, 8'hA0);
      rd(8'h02, 8'hA0);
      wr(8'h02, 8'h20);
      cmp({7'h00, int_n}, 8'h01);
      light_res <= 12'h010;
      wr(8'h02, 8'h01);
      wr(8'h01, 8'h04);
      repeat (450) @(posedge mclk);
      rd(8'h02, 8'h09);
      cmp({7'h00, int_n}, 8'h01);
      near_res <= 8'h20;
      wr(8'h01, 8'hF4);
      en <= 1'b0;
      repeat (100) @(posedge mclk);
      cmp({7'h00, int_n}, 8'h01);
      en <= 1'b1;
      repeat (100) @(posedge mclk);
      cmp({7'h00, int_n}, 8'h00);
      end_of_test();
   end
   initial begin
      #900000;
      n_errors++;
      end_of_test();
   end
endmodule : lpc_sensor_top_tb
